//--- hdl/rxmon_pkg.sv
// package for the receive pcs lock status monitor
package rxmon_pkg;
  // register word indices (byte address = index * 4)
  localparam logic [11:0] IDX_LINK_FAULT   = 12'h308;
  localparam logic [11:0] IDX_CLK_LOCK     = 12'h321;
  localparam logic [11:0] IDX_FRAMING_ERROR_STATE      = 12'h323;
  localparam logic [11:0] IDX_FRM_CLR      = 12'h324;
  localparam logic [11:0] IDX_ALIGN        = 12'h326;
  localparam logic [11:0] IDX_DESKEW       = 12'h329;
  localparam logic [11:0] IDX_FLAG_SEL     = 12'h330;
  localparam logic [11:0] IDX_FLAG_VIEW    = 12'h331;
  localparam logic [11:0] IDX_IRQ_STAT     = 12'h340;
  localparam logic [11:0] IDX_IRQ_MASK     = 12'h341;
  localparam logic [11:0] IDX_CTRL         = 12'h342;
  localparam logic [11:0] IDX_ERR_CNT      = 12'h343;
  // field positions
  localparam int DSK_LOCK_BIT   = 0;
  localparam int DSK_TOGGLE_BIT = 1;
  localparam int CTRL_LF_EN_BIT = 0;
  // interrupt status layout
  localparam int IRQ_LOS        = 0;
  localparam int IRQ_FRM        = 1;
  localparam int IRQ_DSK        = 2;
  localparam int IRQ_RXFULL     = 3;
  localparam int IRQ_W          = 4;
  // reset values
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;
  // deskew and timing
  localparam int MAX_SKEW_WORDS = 16;
  localparam int SOFT_RST_NS    = 100;
  localparam int CLK_PERIOD_NS  = 5;
  localparam int SOFT_RST_CYC   = (SOFT_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // fifo flag groups
  typedef struct packed {
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;
  } rxmon_fifo_t;
  // per-lane receive status
  typedef struct packed {
    logic word_lock;
    logic framing_error_state;
    logic clk_lock;
  } rxmon_lane_t;
endpackage

//--- hdl/rxmon_top.sv
// receive pcs lock status monitor with wishbone register slave
// Summary of operation
// - framing clear held high resets framing errors
// - framing status stays zero after clear while lanes locked and no framing error is reported
// - one clock-lock bit per lane
// - lock bits follow lane clock recovery
// - flag select chooses fifo flags shown
// - flags give tx/rx fifo empty and full
// - deskew lock state in bit zero
// - sticky deskew toggle until reset or clear
// - deskew absorbs up to sixteen words skew
// - alignment bit equals receive aligned output
// - loss of signal drops receive aligned
// - fault option: loss drives local fault
// - link fault bit tracks local fault
// - loss of signal requests receive soft reset
// - diagonal parity per virtual lane
// - data errors fcs, control errors decoding
// - lanes reordered by marker lane tags
`timescale 1ns/10ps
module rxmon_top #(
  parameter int LANES  = 2,
  parameter int VLANES = 4,
  parameter int SKEW_W = 5
) (
  // clock and reset
  input  wire logic                  clk_i,
  input  wire logic                  rst_i,
  // wishbone slave
  input  wire logic                  wb_cyc_i,
  input  wire logic                  wb_stb_i,
  input  wire logic                  wb_we_i,
  input  wire logic [13:0]           wb_adr_i,
  input  wire logic [3:0]            wb_sel_i,
  input  wire logic [31:0]           wb_dat_i,
  output logic      [31:0]           wb_dat_o,
  output logic                       wb_ack_o,
  // lane status from the pcs
  input  wire logic [LANES-1:0]      word_lock_i,
  input  wire logic [LANES-1:0]      framing_error_state_i,
  input  wire logic [LANES-1:0]      clk_lock_i,
  input  wire logic [VLANES-1:0]     am_lock_i,
  input  wire logic [VLANES*2-1:0]   am_tag_i,
  input  wire logic [VLANES*SKEW_W-1:0] vl_skew_i,
  input  wire logic [VLANES-1:0]     bip_err_i,
  input  wire logic                  fcs_err_i,
  input  wire logic                  ctl_err_i,
  input  wire logic                  los_i,
  input  wire logic [3:0]            tx_fifo_flags_i,
  input  wire logic [3:0]            rx_fifo_flags_i,
  // status outputs
  output logic                       rx_aligned_o,
  output logic                       local_fault_o,
  output logic                       soft_rx_rst_o,
  output logic [VLANES*2-1:0]        vl_order_o,
  output logic [VLANES-1:0]          vl_bip_err_o,
  output logic                       fcs_err_o,
  output logic                       mii_dec_err_o,
  output logic                       irq_o
);
  // register state
  localparam int IRQ_W_L = rxmon_pkg::IRQ_W;
  logic [LANES-1:0]   framing_error_state;
  logic               frm_clr;
  logic [31:0]        ctrl;
  logic [7:0]         flag_sel;
  logic               dsk_lock;
  logic               dsk_toggle;
  logic               los_seen;
  logic [7:0]         rst_cnt;
  logic [IRQ_W_L-1:0] irq_stat;
  logic [IRQ_W_L-1:0] irq_mask;
  logic [15:0]        bip_cnt;

  // bus decode
  wire        req      = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire [11:0] idx      = wb_adr_i[13:2];
  wire        wr       = req & wb_we_i & wb_sel_i[0];
  wire        wr_clr   = wr & (idx == rxmon_pkg::IDX_FRM_CLR);
  wire        wr_sel   = wr & (idx == rxmon_pkg::IDX_FLAG_SEL);
  wire        wr_istat = wr & (idx == rxmon_pkg::IDX_IRQ_STAT);
  wire        wr_imask = wr & (idx == rxmon_pkg::IDX_IRQ_MASK);
  wire        wr_ctrl  = wr & (idx == rxmon_pkg::IDX_CTRL);

  // deskew: every lane locked and skew within window
  logic skew_ok;
  always_comb begin
    skew_ok = 1'b1;
    for (int v = 0; v < VLANES; v++) begin
      if (vl_skew_i[v*SKEW_W +: SKEW_W] > SKEW_W'(rxmon_pkg::MAX_SKEW_WORDS)) begin
        skew_ok = 1'b0;
      end
    end
  end
  wire next_dsk_lock = skew_ok & (&am_lock_i) & ~los_i;
  wire aligned_now   = next_dsk_lock & ~los_i;

  // fifo flag view, selected by software
  rxmon_pkg::rxmon_fifo_t txf;
  rxmon_pkg::rxmon_fifo_t rxf;
  assign txf = rxmon_pkg::rxmon_fifo_t'(tx_fifo_flags_i);
  assign rxf = rxmon_pkg::rxmon_fifo_t'(rx_fifo_flags_i);
  wire [7:0] flag_all  = {4'h0, rxf.rx_full, rxf.rx_empty, txf.tx_full, txf.tx_empty};
  wire [7:0] flag_view = flag_all & flag_sel;

  // interrupt events
  wire [IRQ_W_L-1:0] irq_ev = {rxf.rx_full, dsk_lock ^ next_dsk_lock, |framing_error_state_i,
                               los_i & ~los_seen};

  // read mux; status registers are read only except interrupt status, which is write-one clear
  logic [31:0] rdata;
  always_comb begin
    rdata = 32'h0;
    case (idx)
      rxmon_pkg::IDX_LINK_FAULT: rdata = {31'h0, local_fault_o};
      rxmon_pkg::IDX_CLK_LOCK:   rdata = 32'(clk_lock_i);
      rxmon_pkg::IDX_FRAMING_ERROR_STATE:    rdata = 32'(framing_error_state);
      rxmon_pkg::IDX_FRM_CLR:    rdata = {31'h0, frm_clr};
      rxmon_pkg::IDX_ALIGN:      rdata = {31'h0, rx_aligned_o};
      rxmon_pkg::IDX_DESKEW:     rdata = {30'h0, dsk_toggle, dsk_lock};
      rxmon_pkg::IDX_FLAG_SEL:   rdata = {24'h0, flag_sel};
      rxmon_pkg::IDX_FLAG_VIEW:  rdata = {24'h0, flag_view};
      rxmon_pkg::IDX_IRQ_STAT:   rdata = 32'(irq_stat);
      rxmon_pkg::IDX_IRQ_MASK:   rdata = 32'(irq_mask);
      rxmon_pkg::IDX_CTRL:       rdata = ctrl;
      rxmon_pkg::IDX_ERR_CNT:    rdata = {16'h0, bip_cnt};
      default:                   rdata = 32'h0;
    endcase
  end

  // wishbone answer, one cycle after request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata : 32'h0;
    end
  end

  // software registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frm_clr  <= 1'b0;
      flag_sel <= 8'h0;
      ctrl     <= rxmon_pkg::CTRL_RST;
      irq_mask <= rxmon_pkg::MASK_RST;
    end else begin
      if (wr_clr) frm_clr <= wb_dat_i[0];
      if (wr_sel) flag_sel <= wb_dat_i[7:0];
      if (wr_ctrl) ctrl <= wb_dat_i;
      if (wr_imask) irq_mask <= wb_dat_i[IRQ_W_L-1:0];
    end
  end

  // framing error accumulation and deskew sticky bit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      framing_error_state    <= '0;
      dsk_lock   <= 1'b0;
      dsk_toggle <= 1'b0;
    end else begin
      dsk_lock <= next_dsk_lock;
      if (frm_clr) framing_error_state <= '0;
      else framing_error_state <= framing_error_state | framing_error_state_i | ~word_lock_i;
      if (dsk_lock != next_dsk_lock) dsk_toggle <= 1'b1;
      else if (frm_clr) dsk_toggle <= 1'b0;
    end
  end

  // alignment, fault and soft reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rx_aligned_o  <= 1'b0;
      local_fault_o <= 1'b0;
      soft_rx_rst_o <= 1'b0;
      los_seen      <= 1'b0;
      rst_cnt       <= 8'h0;
    end else begin
      los_seen      <= los_i;
      rx_aligned_o  <= aligned_now;
      local_fault_o <= los_i & ctrl[rxmon_pkg::CTRL_LF_EN_BIT];
      if (los_i & ~los_seen) begin
        rst_cnt       <= 8'(rxmon_pkg::SOFT_RST_CYC);
        soft_rx_rst_o <= 1'b1;
      end else if (rst_cnt != 8'h0) begin
        rst_cnt       <= rst_cnt - 8'h1;
        soft_rx_rst_o <= (rst_cnt != 8'h1);
      end else begin
        soft_rx_rst_o <= 1'b0;
      end
    end
  end

  // lane reorder from tags, parity and error classes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vl_order_o    <= '0;
      vl_bip_err_o  <= '0;
      fcs_err_o     <= 1'b0;
      mii_dec_err_o <= 1'b0;
      bip_cnt       <= 16'h0;
    end else begin
      for (int v = 0; v < VLANES; v++) begin
        vl_order_o[am_tag_i[v*2 +: 2]*2 +: 2] <= 2'(v);
      end
      vl_bip_err_o  <= bip_err_i;
      fcs_err_o     <= fcs_err_i;
      mii_dec_err_o <= ctl_err_i;
      if (|bip_err_i && bip_cnt != 16'hffff) bip_cnt <= bip_cnt + 16'h1;
    end
  end

  // interrupt status, set wins over write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_stat <= '0;
      irq_o    <= 1'b0;
    end else begin
      irq_stat <= (irq_stat & ~(wr_istat ? wb_dat_i[IRQ_W_L-1:0] : '0)) | irq_ev;
      irq_o    <= |(((irq_stat & ~(wr_istat ? wb_dat_i[IRQ_W_L-1:0] : '0)) | irq_ev)
                    & irq_mask);
    end
  end

  // checks
  property p_frm_clr;
    @(posedge clk_i) disable iff (rst_i) frm_clr |=> (framing_error_state == '0);
  endproperty
  a_frm_clr: assert property (p_frm_clr) else $error("frm clear failed");
  property p_frm_acc;
    @(posedge clk_i) disable iff (rst_i) (|framing_error_state_i && !frm_clr) |=> (framing_error_state != '0);
  endproperty
  a_frm_acc: assert property (p_frm_acc) else $error("frm not accumulated");
  property p_los_align;
    @(posedge clk_i) disable iff (rst_i) los_i |=> !rx_aligned_o;
  endproperty
  a_los_align: assert property (p_los_align) else $error("aligned during los");
  property p_lf;
    @(posedge clk_i) disable iff (rst_i)
      (los_i && ctrl[rxmon_pkg::CTRL_LF_EN_BIT]) |=> local_fault_o;
  endproperty
  a_lf: assert property (p_lf) else $error("no local fault");
  sequence s_los_rise;
    los_i && !los_seen;
  endsequence
  property p_softrst;
    @(posedge clk_i) disable iff (rst_i) s_los_rise |=> soft_rx_rst_o [*2];
  endproperty
  a_softrst: assert property (p_softrst) else $error("no soft reset");
  property p_dsk_tog;
    @(posedge clk_i) disable iff (rst_i) $changed(dsk_lock) |-> dsk_toggle;
  endproperty
  a_dsk_tog: assert property (p_dsk_tog) else $error("toggle not sticky");
  property p_dsk_skew;
    @(posedge clk_i) disable iff (rst_i) !skew_ok |=> !dsk_lock;
  endproperty
  a_dsk_skew: assert property (p_dsk_skew) else $error("locked beyond skew");
  property p_ack;
    @(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack: assert property (p_ack) else $error("ack held");

  // a read request of one register index
  sequence s_read_of(logic [11:0] a);
    req && !wb_we_i && (idx == a);
  endsequence
  // every request answered next cycle with the mux value
  property p_answer;
    @(posedge clk_i) disable iff (rst_i)
      req |=> (wb_ack_o && (wb_dat_o == $past(rdata)));
  endproperty
  a_answer: assert property (p_answer) else $error("no answer to request");
  // cleared status stays zero while lanes locked and no framing error is reported
  property p_frm_zero;
    @(posedge clk_i) disable iff (rst_i)
      ((framing_error_state == '0) && (&word_lock_i) && !(|framing_error_state_i)) |=> (framing_error_state == '0);
  endproperty
  a_frm_zero: assert property (p_frm_zero) else $error("frm set while locked");
  // clock lock read shows the lane inputs
  property p_clk_rd;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(rxmon_pkg::IDX_CLK_LOCK) |=> (wb_dat_o[LANES-1:0] == $past(clk_lock_i));
  endproperty
  a_clk_rd: assert property (p_clk_rd) else $error("clock lock read wrong");
  // deskew read shows the lock state in bit zero
  property p_dsk_rd;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(rxmon_pkg::IDX_DESKEW) |=> (wb_dat_o[0] == $past(dsk_lock));
  endproperty
  a_dsk_rd: assert property (p_dsk_rd) else $error("deskew read wrong");
  // lock follows the deskew condition
  property p_dsk_follow;
    @(posedge clk_i) disable iff (rst_i)
      next_dsk_lock |=> dsk_lock;
  endproperty
  a_dsk_follow: assert property (p_dsk_follow) else $error("deskew lock missed");
  // alignment read equals the aligned output
  property p_align_rd;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(rxmon_pkg::IDX_ALIGN) |=> (wb_dat_o[0] == $past(rx_aligned_o));
  endproperty
  a_align_rd: assert property (p_align_rd) else $error("alignment read wrong");
  // link fault read equals the fault output
  property p_lf_rd;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(rxmon_pkg::IDX_LINK_FAULT) |=> (wb_dat_o[0] == $past(local_fault_o));
  endproperty
  a_lf_rd: assert property (p_lf_rd) else $error("link fault read wrong");
  // flag view shows selected flags only
  property p_view_rd;
    @(posedge clk_i) disable iff (rst_i)
      s_read_of(rxmon_pkg::IDX_FLAG_VIEW) |=> (wb_dat_o[7:0] == $past(flag_all & flag_sel));
  endproperty
  a_view_rd: assert property (p_view_rd) else $error("flag view wrong");
  // a full receive fifo is flagged
  property p_rxfull;
    @(posedge clk_i) disable iff (rst_i)
      rxf.rx_full |=> irq_stat[rxmon_pkg::IRQ_RXFULL];
  endproperty
  a_rxfull: assert property (p_rxfull) else $error("rx full not flagged");
  // clear drops the toggle when lock is steady
  property p_dsk_clr;
    @(posedge clk_i) disable iff (rst_i)
      (frm_clr && (dsk_lock == next_dsk_lock)) |=> !dsk_toggle;
  endproperty
  a_dsk_clr: assert property (p_dsk_clr) else $error("toggle not cleared");
  // no fault while generation disabled
  property p_lf_off;
    @(posedge clk_i) disable iff (rst_i)
      !ctrl[rxmon_pkg::CTRL_LF_EN_BIT] |=> !local_fault_o;
  endproperty
  a_lf_off: assert property (p_lf_off) else $error("fault while disabled");
  // parity errors reported per virtual lane
  property p_bip;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (vl_bip_err_o == $past(bip_err_i));
  endproperty
  a_bip: assert property (p_bip) else $error("lane parity wrong");
  // data errors reported as fcs errors
  property p_fcs;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (fcs_err_o == $past(fcs_err_i));
  endproperty
  a_fcs: assert property (p_fcs) else $error("fcs error wrong");
  // control errors reported as decoding errors
  property p_mii;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (mii_dec_err_o == $past(ctl_err_i));
  endproperty
  a_mii: assert property (p_mii) else $error("decode error wrong");
  // last virtual lane lands in the slot of its tag
  property p_order;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (vl_order_o[$past(am_tag_i[7:6])*2 +: 2] == 2'h3);
  endproperty
  a_order: assert property (p_order) else $error("lane order wrong");
  // reads leave software state untouched
  property p_ro;
    @(posedge clk_i) disable iff (rst_i)
      (req && !wb_we_i) |=> ($stable(ctrl) && $stable(flag_sel) && $stable(irq_mask));
  endproperty
  a_ro: assert property (p_ro) else $error("read changed state");
  // interrupt level follows unmasked status
  property p_irq_lvl;
    @(posedge clk_i) disable iff (rst_i)
      1'b1 |=> (irq_o == |(irq_stat & $past(irq_mask)));
  endproperty
  a_irq_lvl: assert property (p_irq_lvl) else $error("interrupt level wrong");
  // status bit stays until written
  property p_irq_sticky;
    @(posedge clk_i) disable iff (rst_i)
      (irq_stat[rxmon_pkg::IRQ_LOS] && !wr_istat) |=> irq_stat[rxmon_pkg::IRQ_LOS];
  endproperty
  a_irq_sticky: assert property (p_irq_sticky) else $error("status bit lost");
  // parity error counter counts while below saturation
  property p_bip_cnt;
    @(posedge clk_i) disable iff (rst_i)
      (|bip_err_i && bip_cnt != 16'hffff) |=> (bip_cnt == $past(bip_cnt) + 16'h1);
  endproperty
  a_bip_cnt: assert property (p_bip_cnt) else $error("parity count wrong");
endmodule

//--- verification/rxmon_far_end.sv
// behavioural remote transmitter feeding lane status
`timescale 1ns/10ps
module rxmon_far_end (
  // control from bench
  input  wire logic        clk_i,
  input  wire logic        link_up_i,
  input  wire logic [1:0]  bad_lane_i,
  input  wire logic [4:0]  skew_i,
  // lane status towards the pcs monitor
  output logic      [1:0]  word_lock_o = 2'h0,
  output logic      [1:0]  framing_error_state_o   = 2'h0,
  output logic      [1:0]  clk_lock_o  = 2'h0,
  output logic      [3:0]  am_lock_o   = 4'h0,
  output logic      [7:0]  am_tag_o    = 8'he4,
  output logic      [19:0] vl_skew_o   = 20'h0,
  output logic             los_o       = 1'b1
);
  // lane state follows the link, a bad lane loses lock and clock
  always @(posedge clk_i) begin
    word_lock_o <= {2{link_up_i}} & ~bad_lane_i;
    framing_error_state_o   <= bad_lane_i;
    clk_lock_o  <= {2{link_up_i}} & ~bad_lane_i;
    am_lock_o   <= {4{link_up_i}};
    am_tag_o    <= 8'he4;
    vl_skew_o   <= {4{skew_i}};
    los_o       <= ~link_up_i;
  end
endmodule

//--- verification/tb_top.sv
// self-checking bench for the receive lock status monitor
`timescale 1ns/10ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
  $display("Error at %0t: got %h want %h", $time, a, b); end end
module tb_top;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, link_up = 0;
  logic fcs_err_i = 0, ctl_err_i = 0, los_i, wb_ack_o, rx_aligned_o, local_fault_o;
  logic soft_rx_rst_o, fcs_err_o, mii_dec_err_o, irq_o;
  logic [13:0] wb_adr_i = 0;
  logic [3:0]  wb_sel_i = 0, tx_fifo_flags_i = 0, rx_fifo_flags_i = 0, bip_err_i = 0;
  logic [3:0]  am_lock_i, vl_bip_err_o;
  logic [1:0]  word_lock_i, framing_error_state_i, clk_lock_i, bad = 0;
  logic [7:0]  am_tag_i, vl_order_o;
  logic [19:0] vl_skew_i;
  logic [4:0]  skew = 0;
  logic [31:0] wb_dat_i = 0, wb_dat_o, q;
  int          num_errors = 0, n_checks = 0, cyc_cnt = 0, k;
  rxmon_top DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .word_lock_i, .framing_error_state_i, .clk_lock_i, .am_lock_i,
    .am_tag_i, .vl_skew_i, .bip_err_i, .fcs_err_i, .ctl_err_i, .los_i, .tx_fifo_flags_i,
    .rx_fifo_flags_i, .rx_aligned_o, .local_fault_o, .soft_rx_rst_o, .vl_order_o,
    .vl_bip_err_o, .fcs_err_o, .mii_dec_err_o, .irq_o);
  rxmon_far_end FAR (.clk_i, .link_up_i(link_up), .bad_lane_i(bad), .skew_i(skew),
    .word_lock_o(word_lock_i), .framing_error_state_o(framing_error_state_i), .clk_lock_o(clk_lock_i),
    .am_lock_o(am_lock_i), .am_tag_o(am_tag_i), .vl_skew_o(vl_skew_i), .los_o(los_i));
  // clock and hang guard
  initial forever #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin num_errors++; final_report(); end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // one classic wishbone cycle, held until ack
  task automatic wb(input logic we, input logic [11:0] idx, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hf};
    wb_adr_i <= {idx, 2'b00};
    wb_dat_i <= d;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic t_clear();
    wb(1, rxmon_pkg::IDX_FRM_CLR, 32'h1);
    wb(1, rxmon_pkg::IDX_FRM_CLR, 32'h0);
  endtask
  task automatic t_link();
    skew <= 5'd16;
    link_up <= 1;
    idle(8);
    t_clear();
    wb(0, rxmon_pkg::IDX_FRAMING_ERROR_STATE, 0); `CHK(q, 32'h0)
    wb(0, rxmon_pkg::IDX_CLK_LOCK, 0); `CHK(q[1:0], 2'h3)
    wb(0, rxmon_pkg::IDX_ALIGN, 0); `CHK(q[0], rx_aligned_o)
    `CHK(rx_aligned_o, 1'b1)
    wb(0, rxmon_pkg::IDX_DESKEW, 0); `CHK(q[1:0], 2'h1)
    `CHK(vl_order_o, 8'he4)
    wb(1, rxmon_pkg::IDX_ALIGN, 0); wb(0, rxmon_pkg::IDX_ALIGN, 0); `CHK(q[0], 1'b1)
    $display("link test done");
  endtask
  task automatic t_skew();
    skew <= 5'd17;
    idle(6);
    `CHK(rx_aligned_o, 1'b0)
    skew <= 5'd16;
    idle(6);
    wb(0, rxmon_pkg::IDX_DESKEW, 0); `CHK(q[1:0], 2'h3)
    t_clear();
    wb(0, rxmon_pkg::IDX_DESKEW, 0); `CHK(q[1:0], 2'h1)
    $display("skew test done");
  endtask
  task automatic t_lane();
    bad <= 2'h1;
    idle(4);
    wb(0, rxmon_pkg::IDX_CLK_LOCK, 0); `CHK(q[1:0], 2'h2)
    bad <= 2'h0;
    idle(4);
    wb(0, rxmon_pkg::IDX_FRAMING_ERROR_STATE, 0); `CHK(q[0], 1'b1)
    t_clear();
    wb(0, rxmon_pkg::IDX_FRAMING_ERROR_STATE, 0); `CHK(q, 32'h0)
    $display("lane test done");
  endtask
  task automatic t_misc();
    tx_fifo_flags_i <= 4'h8;
    rx_fifo_flags_i <= 4'h1;
    wb(1, rxmon_pkg::IDX_FLAG_SEL, 32'hff);
    wb(0, rxmon_pkg::IDX_FLAG_VIEW, 0); `CHK(q[3:0], 4'h9)
    {fcs_err_i, ctl_err_i, bip_err_i} <= 6'h35;
    @(posedge clk_i);
    {fcs_err_i, ctl_err_i, bip_err_i} <= 6'h00;
    #1 `CHK({fcs_err_o, mii_dec_err_o, vl_bip_err_o}, 6'h35)
    wb(0, rxmon_pkg::IDX_ERR_CNT, 0); `CHK(q, 32'h1)
    wb(0, 12'h3ff, 0); `CHK(q, 32'h0)
    $display("misc test done");
  endtask
  task automatic t_los(input logic en);
    wb(1, rxmon_pkg::IDX_CTRL, {31'h0, en});
    wb(1, rxmon_pkg::IDX_IRQ_MASK, 32'h0);
    wb(1, rxmon_pkg::IDX_IRQ_STAT, 32'hf);
    k = 0;
    link_up <= 0;
    repeat (40) begin @(posedge clk_i); if (soft_rx_rst_o === 1'b1) k++; end
    `CHK(k, rxmon_pkg::SOFT_RST_CYC)
    `CHK(rx_aligned_o, 1'b0)
    `CHK(local_fault_o, en)
    wb(0, rxmon_pkg::IDX_LINK_FAULT, 0); `CHK(q[0], local_fault_o)
    `CHK(irq_o, 1'b0)
    wb(1, rxmon_pkg::IDX_IRQ_MASK, 32'h1); idle(2); `CHK(irq_o, 1'b1)
    wb(1, rxmon_pkg::IDX_IRQ_STAT, 32'h1); idle(2); `CHK(irq_o, 1'b0)
    link_up <= 1;
    idle(8);
    $display("loss test done");
  endtask
  // main sequence
  initial begin
    idle(3);
    rst_i <= 0;
    wb(0, rxmon_pkg::IDX_CTRL, 0); `CHK(q, rxmon_pkg::CTRL_RST)
    t_link();
    t_skew();
    t_lane();
    t_misc();
    t_los(1);
    t_los(0);
    final_report();
  end
endmodule
